// [can_bit_timing_and_control_regs.v]
// bit timing, command strobes, capture and divider registers of a can node
// assumes a classic wishbone master and a protocol core beside it that
// reports bus errors, arbitration loss and overrun, and reads the strobes
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
`include "can_regs_defines.vh"
module can_bit_timing_and_control_regs (
	input  wire        clk,              // oscillator clock, 20 MHz
	input  wire        rst,              // async hardware reset
	input  wire        ce,               // clock enable
	input  wire [8:0]  adr_i,            // wishbone byte address
	input  wire [31:0] dat_i,            // wishbone write data
	output reg  [31:0] dat_o,            // wishbone read data
	input  wire        we_i,             // wishbone write enable
	input  wire [3:0]  sel_i,            // wishbone byte selects
	input  wire        stb_i,            // wishbone strobe
	input  wire        cyc_i,            // wishbone cycle
	output reg         ack_o,            // wishbone acknowledge
	input  wire        resetMode,        // controller held in reset mode
	input  wire        rxLine,           // bus receive level
	input  wire        sendBusy,         // a send has already started
	input  wire        overrunEvent,     // receive overrun detected
	input  wire        busErrorEvent,    // bus error detected
	input  wire [7:0]  errorCode,        // type, direction, segment
	input  wire        arbLossEvent,     // arbitration lost
	input  wire [4:0]  arbLossPos,       // bit position of the loss
	output reg         sendRequest,      // send strobe
	output reg         abortPendingSend, // abort strobe
	output reg         releaseRxBuffer,  // release strobe
	output reg         selfReceiveReq,   // self receive strobe
	output reg         overrunStatus,    // overrun status flag
	output reg         overrunIrqEvent,  // overrun rising pulse
	output reg         errCaptured,      // error capture holds a value
	output reg         arbCaptured,      // loss capture holds a value
	output reg  [7:0]  warningThreshold, // limit in force
	output reg         tqTick,           // one quantum elapsed
	output reg         bitStart,         // sync segment begins
	output reg         samplePoint,      // sample point pulse
	output reg         sampledBit,       // sampled bus level
	output wire        dividedClockPin   // divided clock pin
);
	reg  [7:0] bitTimingZero;
	reg  [7:0] bitTimingOne;
	reg  [7:0] outputClockDivider;
	reg  [7:0] warningLimit;
	reg  [7:0] errorCapture;
	reg  [4:0] arbLossCapture;
	reg        resetModeQ;

	wire [6:0] idx;
	wire       access;
	wire       wrDone;
	wire       rdDone;
	wire       wrByte;

	assign idx    = adr_i[8:2];
	assign access = cyc_i & stb_i;
	// a transfer completes on the edge where ack is seen high
	assign wrDone = access & ack_o & we_i;
	assign rdDone = access & ack_o & ~we_i;
	assign wrByte = wrDone & sel_i[0];

	// fields
	wire [1:0] resyncJumpWidth;
	wire [5:0] quantumPrescaler;
	wire       tripleSampleSelect;
	wire [2:0] phaseAfterSample;
	wire [3:0] phaseBeforeSample;

	assign resyncJumpWidth    = bitTimingZero[`T0_JUMP_HI:`T0_JUMP_LO];
	assign quantumPrescaler   = bitTimingZero[`T0_PRESC_HI:0];
	assign tripleSampleSelect = bitTimingOne[`T1_TRIPLE];
	assign phaseAfterSample   = bitTimingOne[`T1_AFTER_HI:`T1_AFTER_LO];
	assign phaseBeforeSample  = bitTimingOne[`T1_BEFORE_HI:0];

	// bus slave: ack one cycle after the request, dropped the next cycle
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			ack_o <= 1'b0;
		end else if (ce) begin
			ack_o <= access & ~ack_o;
		end
	end

	reg [7:0] readByte;

	always @* begin
		case (idx)
		`IDX_COMMAND:     readByte = 8'h00;
		`IDX_TIMING0:     readByte = bitTimingZero;
		`IDX_TIMING1:     readByte = bitTimingOne;
		`IDX_ARB_LOSS:    readByte = {3'h0, arbLossCapture};
		`IDX_ERR_CAPTURE: readByte = errorCapture;
		`IDX_WARN_LIMIT:  readByte = warningLimit;
		`IDX_CLK_DIV:     readByte = outputClockDivider;
		default:          readByte = 8'h00;
		endcase
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			dat_o <= 32'h0000_0000;
		end else if (ce) begin
			if (access & ~ack_o)
				dat_o <= {24'h00_0000, readByte};
			else
				dat_o <= 32'h0000_0000;
		end
	end

	// configuration registers
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			bitTimingZero      <= `RST_TIMING0;
			bitTimingOne       <= `RST_TIMING1;
			outputClockDivider <= `RST_CLK_DIV;
			warningLimit       <= `RST_WARN_LIMIT;
		end else if (ce && wrByte) begin
			// timing may not move while frames are on the bus
			if (idx == `IDX_TIMING0 && resetMode)
				bitTimingZero <= dat_i[7:0];
			if (idx == `IDX_TIMING1 && resetMode)
				bitTimingOne <= dat_i[7:0];
			if (idx == `IDX_WARN_LIMIT && resetMode)
				warningLimit <= dat_i[7:0];
			// software reset mode does not touch the divider
			if (idx == `IDX_CLK_DIV)
				outputClockDivider <= {2'h3, 2'h0, dat_i[3:0]};
		end
	end

	// the limit in force follows the register only on leaving reset mode
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			resetModeQ       <= 1'b1;
			warningThreshold <= `RST_WARN_LIMIT;
		end else if (ce) begin
			resetModeQ <= resetMode;
			if (resetModeQ && !resetMode)
				warningThreshold <= warningLimit;
		end
	end

	// command strobes, one cycle each, from the completed write
	wire cmdWrite;
	assign cmdWrite = wrByte && (idx == `IDX_COMMAND);

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			sendRequest      <= 1'b0;
			abortPendingSend <= 1'b0;
			releaseRxBuffer  <= 1'b0;
			selfReceiveReq   <= 1'b0;
		end else if (ce) begin
			sendRequest      <= cmdWrite & dat_i[`CMD_SEND];
			// an abort after the send has begun has no effect
			abortPendingSend <= cmdWrite & dat_i[`CMD_ABORT] &
				~sendBusy;
			releaseRxBuffer  <= cmdWrite & dat_i[`CMD_RELEASE];
			selfReceiveReq   <= cmdWrite & dat_i[`CMD_SELF_RX];
		end
	end

	// overrun status: a new overrun in the clearing cycle wins
	wire clrOverrun;
	assign clrOverrun = cmdWrite & dat_i[`CMD_CLR_OVERRUN];

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			overrunStatus   <= 1'b0;
			overrunIrqEvent <= 1'b0;
		end else if (ce) begin
			if (overrunEvent)
				overrunStatus <= 1'b1;
			else if (clrOverrun)
				overrunStatus <= 1'b0;
			// only a rising status raises the event
			overrunIrqEvent <= overrunEvent & ~overrunStatus;
		end
	end

	// capture registers rearm when software reads them
	wire rdErr;
	wire rdArb;
	assign rdErr = rdDone && (idx == `IDX_ERR_CAPTURE);
	assign rdArb = rdDone && (idx == `IDX_ARB_LOSS);

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			errorCapture   <= 8'h00;
			errCaptured    <= 1'b0;
			arbLossCapture <= 5'h00;
			arbCaptured    <= 1'b0;
		end else if (ce) begin
			// a capture landing with the read is kept, not lost
			if (busErrorEvent && (!errCaptured || rdErr)) begin
				errorCapture <= errorCode;
				errCaptured  <= 1'b1;
			end else if (rdErr) begin
				errCaptured <= 1'b0;
			end
			if (arbLossEvent && (!arbCaptured || rdArb)) begin
				arbLossCapture <= arbLossPos;
				arbCaptured    <= 1'b1;
			end else if (rdArb) begin
				arbCaptured <= 1'b0;
			end
		end
	end

	// quantum prescaler: 2 * (prescaler + 1) oscillator cycles
	reg  [6:0] preCnt;
	wire [6:0] preLast;
	assign preLast = {quantumPrescaler, 1'b1};

	// bit segment sequencer
	reg  [1:0] seg;
	reg  [5:0] qCnt;
	reg  [2:0] extendAmt;
	reg  [2:0] shrinkAmt;
	reg        resyncDone;
	reg        rxPrev;
	reg  [1:0] sampHist;

	wire [5:0] beforeLen;
	wire [5:0] afterLen;
	wire [2:0] jumpQuanta;
	wire [5:0] afterLeft;
	wire       fallEdge;
	wire       quantum;
	wire       majority;

	assign jumpQuanta = {1'b0, resyncJumpWidth} + 3'h1;
	assign beforeLen  = {2'h0, phaseBeforeSample} + 6'h01 +
		{3'h0, extendAmt};
	assign afterLen   = {3'h0, phaseAfterSample} + 6'h01 -
		{3'h0, shrinkAmt};
	assign afterLeft  = afterLen - qCnt;
	assign fallEdge   = rxPrev & ~rxLine;
	assign quantum    = (preCnt == preLast);
	assign majority   = (sampHist[1] & sampHist[0]) |
		(sampHist[1] & rxLine) | (sampHist[0] & rxLine);

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			preCnt      <= 7'h00;
			seg         <= `SEG_SYNC;
			qCnt        <= 6'h00;
			extendAmt   <= 3'h0;
			shrinkAmt   <= 3'h0;
			resyncDone  <= 1'b0;
			rxPrev      <= 1'b1;
			sampHist    <= 2'h3;
			tqTick      <= 1'b0;
			bitStart    <= 1'b0;
			samplePoint <= 1'b0;
			sampledBit  <= 1'b1;
		end else if (ce) begin
			rxPrev      <= rxLine;
			tqTick      <= 1'b0;
			bitStart    <= 1'b0;
			samplePoint <= 1'b0;
			if (resetMode) begin
				// idle while configuration may change
				preCnt     <= 7'h00;
				seg        <= `SEG_SYNC;
				qCnt       <= 6'h00;
				extendAmt  <= 3'h0;
				shrinkAmt  <= 3'h0;
				resyncDone <= 1'b0;
			end else if (fallEdge && !resyncDone &&
				seg == `SEG_BEFORE) begin
				// late edge: stretch the segment before sampling
				resyncDone <= 1'b1;
				if (qCnt[5:3] == 3'h0 && qCnt[2:0] < jumpQuanta)
					extendAmt <= qCnt[2:0];
				else
					extendAmt <= jumpQuanta;
				preCnt <= quantum ? 7'h00 : preCnt + 7'h01;
				if (quantum)
					qCnt <= qCnt + 6'h01;
				tqTick <= quantum;
			end else if (fallEdge && !resyncDone &&
				seg == `SEG_AFTER) begin
				// early edge: cut the segment after sampling
				resyncDone <= 1'b1;
				if (afterLeft <= {3'h0, jumpQuanta}) begin
					// the edge stands in for the next sync quantum
					seg       <= `SEG_BEFORE;
					qCnt      <= 6'h00;
					preCnt    <= 7'h00;
					extendAmt <= 3'h0;
					shrinkAmt <= 3'h0;
					bitStart  <= 1'b1;
				end else begin
					shrinkAmt <= jumpQuanta;
					preCnt    <= quantum ? 7'h00 : preCnt + 7'h01;
					tqTick    <= quantum;
					if (quantum)
						qCnt <= qCnt + 6'h01;
				end
			end else if (quantum) begin
				preCnt <= 7'h00;
				tqTick <= 1'b1;
				case (seg)
				`SEG_SYNC: begin
					// sync lasts one quantum only
					seg        <= `SEG_BEFORE;
					qCnt       <= 6'h00;
					extendAmt  <= 3'h0;
					shrinkAmt  <= 3'h0;
					resyncDone <= 1'b0;
				end
				`SEG_BEFORE: begin
					sampHist <= {sampHist[0], rxLine};
					if (qCnt + 6'h01 >= beforeLen) begin
						seg         <= `SEG_AFTER;
						qCnt        <= 6'h00;
						samplePoint <= 1'b1;
						// the two quanta before the point join the vote
						sampledBit  <= tripleSampleSelect ?
							majority : rxLine;
					end else begin
						qCnt <= qCnt + 6'h01;
					end
				end
				`SEG_AFTER: begin
					if (qCnt + 6'h01 >= afterLen) begin
						seg      <= `SEG_SYNC;
						qCnt     <= 6'h00;
						bitStart <= 1'b1;
					end else begin
						qCnt <= qCnt + 6'h01;
					end
				end
				default: begin
					seg  <= `SEG_SYNC;
					qCnt <= 6'h00;
				end
				endcase
			end else begin
				preCnt <= preCnt + 7'h01;
			end
		end
	end

	clock_out_divider divider (
		.clk    (clk),
		.rst    (rst),
		.ce     (ce),
		.code   (outputClockDivider[`CD_CODE_HI:0]),
		.off    (outputClockDivider[`CD_OFF]),
		.clkPin (dividedClockPin)
	);
endmodule

// [can_bus_node.sv]
// behavioural model of another node driving the shared bus line
// assumes a frame is started only after the previous one has ended
`timescale 1ns/1ps
module can_bus_node (
	input  wire        clk,    // node clock
	input  wire        rst,    // async reset
	input  wire        go,     // start a frame
	input  wire [15:0] frame,  // levels sent msb first
	input  wire [7:0]  bitLen, // clocks per bit
	output reg         rxLine  // bus level, 1 is recessive
);
	int pos;
	int tick;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rxLine <= 1'b1;
			pos <= 16;
			tick <= 0;
		end else if (go && pos == 16) begin
			rxLine <= frame[15];
			pos <= 0;
			tick <= 0;
		end else if (pos < 16 && tick == bitLen - 1) begin
			// the pull-up takes the line recessive once the frame ends
			rxLine <= pos == 15 ? 1'b1 : frame[14 - pos];
			pos <= pos + 1;
			tick <= 0;
		end else if (pos < 16) begin
			tick <= tick + 1;
		end
	end
endmodule

// [can_regs_defines.vh]
// constants for the can bit timing and control register block
// assumes an 8 bit register set reached as 32 bit wishbone words
// How it works
// - timing word zero holds jump width in bits 7:6, prescaler in bits 5:0
// - jump width caps quanta a bit is stretched or cut on resync edges
// - one quantum lasts two oscillator periods times prescaler plus one
// - sampling select high takes three samples per bit, low takes one
// - segment fields in bits 3:0 and 6:4 give value plus one quanta
// - a bit opens with a sync segment of exactly one quantum unless an early edge within jump width stands in for it
// - hardware reset loads the clock divider register with 0xc0
// - software reset leaves the clock divider register untouched
// - divide code gives osc over 2 to 14, code 7 passes osc directly
// - bit 3 of the clock divider register switches the clock pin off
// - command register is write only and reads back as zero
// - self receive bit starts a send that this node also receives
// - abort bit cancels a pending send only before it has started
// - release bit frees the current receive buffer message
// - clear overrun bit clears overrun status; no new overrun event while set
// - bus error captures its type, direction and segment, holds it until read, then rearms
// - error capture holds type 7:6, direction 5, segment 4:0
// - loss codes 13 to 30 for later identifier bits, 31 for remote bit
// - warning limit holds the error count that raises the warning event
// - warning limit written only in reset mode, applied on leaving it
// - hardware reset sets the warning limit to 96
// - arbitration loss captures position, holds until read, codes 0 to 31
`ifndef CAN_REGS_DEFINES_VH
`define CAN_REGS_DEFINES_VH

// register indices; byte address is four times the index
`define IDX_COMMAND     7'h01
`define IDX_TIMING0     7'h06
`define IDX_TIMING1     7'h07
`define IDX_ARB_LOSS    7'h0b
`define IDX_ERR_CAPTURE 7'h0c
`define IDX_WARN_LIMIT  7'h0d
`define IDX_CLK_DIV     7'h1f

// command bits
`define CMD_SEND        0
`define CMD_ABORT       1
`define CMD_RELEASE     2
`define CMD_CLR_OVERRUN 3
`define CMD_SELF_RX     4

// field positions
`define T0_JUMP_HI      7
`define T0_JUMP_LO      6
`define T0_PRESC_HI     5
`define T1_TRIPLE       7
`define T1_AFTER_HI     6
`define T1_AFTER_LO     4
`define T1_BEFORE_HI    3
`define CD_OFF          3
`define CD_CODE_HI      2
`define CD_CODE_PASS    3'h7

// reset values
`define RST_CLK_DIV     8'hc0
`define RST_WARN_LIMIT  8'h60
`define RST_TIMING0     8'h00
`define RST_TIMING1     8'h00

// bit timing segment states
`define SEG_SYNC        2'h0
`define SEG_BEFORE      2'h1
`define SEG_AFTER       2'h2

`endif

// [can_regs_properties.sv]
// assertions on the ports of the can timing and control register block
// assumes ce stays high and the master runs classic single cycles
`timescale 1ns/1ps
module can_regs_properties (
	input wire        clk,              // clock
	input wire        rst,              // async reset
	input wire [8:0]  adr_i,            // byte address
	input wire [31:0] dat_i,            // write data
	input wire [31:0] dat_o,            // read data
	input wire        we_i,             // write enable
	input wire [3:0]  sel_i,            // byte selects
	input wire        stb_i,            // strobe
	input wire        cyc_i,            // cycle
	input wire        ack_o,            // acknowledge
	input wire        resetMode,        // reset mode
	input wire        sendBusy,         // send started
	input wire        overrunEvent,     // overrun in
	input wire        busErrorEvent,    // bus error in
	input wire        arbLossEvent,     // loss in
	input wire        abortPendingSend, // abort strobe
	input wire        releaseRxBuffer,  // release strobe
	input wire        selfReceiveReq,   // self receive strobe
	input wire        overrunStatus,    // overrun flag
	input wire        overrunIrqEvent,  // overrun pulse
	input wire        errCaptured,      // error capture full
	input wire        arbCaptured,      // loss capture full
	input wire [7:0]  warningThreshold  // limit in force
);
	wire req    = cyc_i && stb_i;
	wire wrCmd  = req && ack_o && we_i && sel_i[0] && adr_i[8:2] == 7'h01;
	wire rdErr  = req && ack_o && !we_i && adr_i[8:2] == 7'h0c;
	wire selfW  = wrCmd && dat_i[4];
	wire relW   = wrCmd && dat_i[2];
	wire abortW = wrCmd && dat_i[1] && !sendBusy;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property p_cmd_zero;
		req && !we_i && !ack_o && adr_i[8:2] == 7'h01 |=> dat_o == 32'h0000_0000;
	endproperty
	property p_self_rx; selfReceiveReq == $past(selfW); endproperty
	property p_abort; abortPendingSend == $past(abortW); endproperty
	property p_release; releaseRxBuffer == $past(relW); endproperty
	property p_ovr_set; overrunEvent |=> overrunStatus; endproperty
	property p_ovr_irq;
		overrunIrqEvent |-> $past(overrunEvent) && !$past(overrunStatus);
	endproperty
	property p_ovr_clr; wrCmd && dat_i[3] && !overrunEvent |=> !overrunStatus;
	endproperty
	property p_err_hold; errCaptured && !rdErr |=> errCaptured; endproperty
	property p_err_rearm; rdErr && !busErrorEvent |=> !errCaptured; endproperty
	property p_arb_load; arbLossEvent |=> arbCaptured; endproperty
	property p_warn_hold; resetMode [*2] |-> $stable(warningThreshold);
	endproperty
	a_cmd_zero: assert property (p_cmd_zero)
		else $error("command read not zero");
	a_self_rx: assert property (p_self_rx)
		else $error("self receive strobe wrong");
	a_abort: assert property (p_abort)
		else $error("abort strobe wrong");
	a_release: assert property (p_release)
		else $error("release strobe wrong");
	a_ovr_set: assert property (p_ovr_set)
		else $error("overrun not set");
	a_ovr_irq: assert property (p_ovr_irq)
		else $error("overrun pulse while status set");
	a_ovr_clr: assert property (p_ovr_clr)
		else $error("overrun not cleared");
	a_err_hold: assert property (p_err_hold)
		else $error("error capture dropped");
	a_err_rearm: assert property (p_err_rearm)
		else $error("error capture not rearmed");
	a_arb_load: assert property (p_arb_load)
		else $error("loss capture not loaded");
	a_warn_hold: assert property (p_warn_hold)
		else $error("limit changed in reset mode");
	c_abort_refused: cover property (wrCmd && dat_i[1] && sendBusy);
	c_err_read: cover property (rdErr && errCaptured);
	c_mode_exit: cover property ($fell(resetMode));
endmodule

bind can_bit_timing_and_control_regs can_regs_properties chk_u (
	.clk(clk), .rst(rst), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
	.we_i(we_i), .sel_i(sel_i), .stb_i(stb_i), .cyc_i(cyc_i), .ack_o(ack_o),
	.resetMode(resetMode), .sendBusy(sendBusy), .overrunEvent(overrunEvent),
	.busErrorEvent(busErrorEvent), .arbLossEvent(arbLossEvent),
	.abortPendingSend(abortPendingSend), .releaseRxBuffer(releaseRxBuffer),
	.selfReceiveReq(selfReceiveReq), .overrunStatus(overrunStatus),
	.overrunIrqEvent(overrunIrqEvent), .errCaptured(errCaptured),
	.arbCaptured(arbCaptured), .warningThreshold(warningThreshold)
);

// [clock_out_divider.v]
// divided clock for the external clock pin
// assumes clk is the oscillator input and ce freezes the divider
`timescale 1ns/1ps
`include "can_regs_defines.vh"
module clock_out_divider (
	input  wire       clk,      // oscillator clock
	input  wire       rst,      // async reset, active high
	input  wire       ce,       // clock enable
	input  wire [2:0] code,     // divide code
	input  wire       off,      // pin disable
	output wire       clkPin    // divided clock out
);
	reg  [2:0] cnt;
	reg        phase;

	// half period is code plus one cycles, giving osc over 2 to 14
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt   <= 3'h0;
			phase <= 1'b0;
		end else if (ce) begin
			if (cnt >= code) begin
				cnt   <= 3'h0;
				phase <= ~phase;
			end else begin
				cnt <= cnt + 3'h1;
			end
		end
	end

	// code 7 passes the oscillator straight through the pin
	assign clkPin = off ? 1'b0 :
		(code == `CD_CODE_PASS) ? clk : phase;
endmodule

// [tb_can_bit_timing_and_control_regs.sv]
// self-checking bench for the can timing and control register block
// assumes the design, the bus node model and the checker compile first
`timescale 1ns/1ps
module tb_can_bit_timing_and_control_regs;
	logic        clk, rst, ce, we_i, stb_i, cyc_i, resetMode, sendBusy, go;
	logic        overrunEvent, busErrorEvent, arbLossEvent;
	logic [8:0]  adr_i;
	logic [31:0] dat_i;
	logic [3:0]  sel_i;
	logic [7:0]  errorCode, rd;
	logic [4:0]  arbLossPos;
	logic [15:0] frame;
	wire  [31:0] dat_o;
	wire  [7:0]  warningThreshold;
	wire         ack_o, rxLine, sendRequest, abortPendingSend, releaseRxBuffer;
	wire         selfReceiveReq, overrunStatus, overrunIrqEvent, errCaptured;
	wire         arbCaptured, tqTick, bitStart, sampledBit, dividedClockPin;
	wire         samplePoint;
	wire  [5:0]  strobes;
	int          fail_count, cmp_count, n, k;
	int          cnt [6];
	int          lossCodes [5] = '{0, 12, 13, 30, 31};
	// slot 3 is the overrun clear, which has no strobe of its own
	assign strobes = {overrunIrqEvent, selfReceiveReq, 1'b0, releaseRxBuffer,
		abortPendingSend, sendRequest};
	can_bit_timing_and_control_regs dut_u (
		.clk(clk), .rst(rst), .ce(ce), .adr_i(adr_i), .dat_i(dat_i),
		.dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .stb_i(stb_i),
		.cyc_i(cyc_i), .ack_o(ack_o), .resetMode(resetMode), .rxLine(rxLine),
		.sendBusy(sendBusy), .overrunEvent(overrunEvent),
		.busErrorEvent(busErrorEvent), .errorCode(errorCode),
		.arbLossEvent(arbLossEvent), .arbLossPos(arbLossPos),
		.sendRequest(sendRequest), .abortPendingSend(abortPendingSend),
		.releaseRxBuffer(releaseRxBuffer), .selfReceiveReq(selfReceiveReq),
		.overrunStatus(overrunStatus), .overrunIrqEvent(overrunIrqEvent),
		.errCaptured(errCaptured), .arbCaptured(arbCaptured),
		.warningThreshold(warningThreshold), .tqTick(tqTick),
		.bitStart(bitStart), .samplePoint(samplePoint),
		.sampledBit(sampledBit),
		.dividedClockPin(dividedClockPin));
	can_bus_node node_u (.clk(clk), .rst(rst), .go(go), .frame(frame),
		.bitLen(8'h18), .rxLine(rxLine));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk)
		for (int i = 0; i < 6; i++)
			if (strobes[i] === 1'b1)
				cnt[i]++;
	task stop_test;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// outputs are read in the active region of the edge, before they update
	task wb(input [6:0] idx, input w, input [7:0] wd);
		int t;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		sel_i <= 4'h1;
		adr_i <= {idx, 2'b00};
		dat_i <= {24'h00_0000, wd};
		for (t = 0; t < 20 && ack_o !== 1'b1; t++)
			@(posedge clk);
		if (t == 20) begin
			fail_count++;
			stop_test;
		end
		rd = dat_o[7:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		@(posedge clk);
	endtask
	task rdchk(input [6:0] idx, input [7:0] exp);
		wb(idx, 1'b0, 8'h00);
		chk(rd, exp);
	endtask
	task pulse(input int w);
		overrunEvent <= w == 0;
		busErrorEvent <= w == 1;
		arbLossEvent <= w == 2;
		@(posedge clk);
		{overrunEvent, busErrorEvent, arbLossEvent} <= 3'b000;
		repeat (3) @(posedge clk);
	endtask
	function logic pick(input int w);
		return w == 0 ? tqTick : w == 1 ? bitStart :
			w == 3 ? samplePoint : dividedClockPin;
	endfunction
	// clocks between two rising edges of the picked output
	task gap(input int w, output int g);
		int t, first;
		logic prev;
		first = -1;
		g = 0;
		prev = pick(w);
		for (t = 0; t < 400 && g == 0; t++) begin
			@(posedge clk);
			if (pick(w) === 1'b1 && prev !== 1'b1) begin
				if (first >= 0)
					g = t - first;
				first = t;
			end
			prev = pick(w);
		end
		if (g == 0) begin
			fail_count++;
			stop_test;
		end
	endtask
	task t_regs;
		rdchk(7'h0d, 8'h60);
		rdchk(7'h1f, 8'hc0);
		rdchk(7'h01, 8'h00);
		rdchk(7'h05, 8'h00);
		chk(warningThreshold, 8'h60);
		$display("reset values done");
	endtask
	task t_timing;
		resetMode <= 1'b1;
		wb(7'h06, 1'b1, 8'h41);
		wb(7'h07, 1'b1, 8'h12);
		rdchk(7'h06, 8'h41);
		rdchk(7'h07, 8'h12);
		resetMode <= 1'b0;
		wb(7'h06, 1'b1, 8'hff);
		rdchk(7'h06, 8'h41);
		gap(0, n);
		chk(n, 4);
		gap(1, n);
		chk(n, 24);
		gap(3, n);
		chk(n, 24);
		for (k = 0; k < 2; k++) begin
			resetMode <= 1'b1;
			wb(7'h07, 1'b1, {k[0], 7'h12});
			resetMode <= 1'b0;
			frame <= 16'h00ff;
			go <= 1'b1;
			@(posedge clk);
			go <= 1'b0;
			repeat (96) @(posedge clk);
			chk(sampledBit, 0);
			repeat (240) @(posedge clk);
			chk(sampledBit, 1);
			// the node ignores a start until its current frame has ended
			repeat (60) @(posedge clk);
		end
		$display("bit timing done");
	endtask
	task t_divider;
		for (k = 0; k < 7; k++) begin
			wb(7'h1f, 1'b1, k[7:0]);
			gap(2, n);
			chk(n, 2 * k + 2);
		end
		// with the enable low the divider must hold its phase
		ce <= 1'b0;
		@(posedge clk);
		rd = {7'h00, dividedClockPin};
		repeat (10) @(posedge clk);
		chk(dividedClockPin, rd);
		ce <= 1'b1;
		wb(7'h1f, 1'b1, 8'h07);
		#12 chk(dividedClockPin, 1);
		#25 chk(dividedClockPin, 0);
		@(posedge clk);
		wb(7'h1f, 1'b1, 8'h08);
		repeat (5) begin
			#10 chk(dividedClockPin, 0);
			@(posedge clk);
		end
		wb(7'h1f, 1'b1, 8'h03);
		resetMode <= 1'b1;
		repeat (2) @(posedge clk);
		resetMode <= 1'b0;
		rdchk(7'h1f, 8'hc3);
		$display("clock divider done");
	endtask
	task t_command;
		for (k = 0; k < 5; k++) begin
			cnt = '{default: 0};
			wb(7'h01, 1'b1, 8'h01 << k);
			repeat (3) @(posedge clk);
			chk(cnt[k], k != 3);
			chk(cnt[0] + cnt[1] + cnt[2] + cnt[4], k != 3);
		end
		cnt = '{default: 0};
		sendBusy <= 1'b1;
		wb(7'h01, 1'b1, 8'h17);
		sendBusy <= 1'b0;
		repeat (3) @(posedge clk);
		chk(cnt[1], 0);
		chk(cnt[0] + cnt[2] + cnt[4], 3);
		$display("command strobes done");
	endtask
	task t_overrun;
		cnt[5] = 0;
		pulse(0);
		chk(overrunStatus, 1);
		pulse(0);
		chk(cnt[5], 1);
		wb(7'h01, 1'b1, 8'h08);
		chk(overrunStatus, 0);
		pulse(0);
		chk(cnt[5], 2);
		$display("overrun done");
	endtask
	task t_capture;
		errorCode <= 8'ha5;
		pulse(1);
		errorCode <= 8'h3c;
		pulse(1);
		rdchk(7'h0c, 8'ha5);
		chk(errCaptured, 0);
		pulse(1);
		rdchk(7'h0c, 8'h3c);
		foreach (lossCodes[i]) begin
			arbLossPos <= lossCodes[i][4:0];
			pulse(2);
			chk(arbCaptured, 1);
			rdchk(7'h0b, lossCodes[i][7:0]);
		end
		$display("captures done");
	endtask
	task t_warn;
		resetMode <= 1'b1;
		wb(7'h0d, 1'b1, 8'h20);
		chk(warningThreshold, 8'h60);
		rdchk(7'h0d, 8'h20);
		resetMode <= 1'b0;
		repeat (3) @(posedge clk);
		chk(warningThreshold, 8'h20);
		wb(7'h0d, 1'b1, 8'h44);
		rdchk(7'h0d, 8'h20);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdchk(7'h1f, 8'hc0);
		rdchk(7'h0d, 8'h60);
		$display("warning limit done");
	endtask
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		{cyc_i, stb_i, we_i, go, sendBusy, resetMode} = 6'h00;
		{overrunEvent, busErrorEvent, arbLossEvent} = 3'h0;
		adr_i = 9'h000;
		dat_i = 32'h0000_0000;
		sel_i = 4'h0;
		errorCode = 8'h00;
		arbLossPos = 5'h00;
		frame = 16'hffff;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_regs;
		t_timing;
		t_divider;
		t_command;
		t_overrun;
		t_capture;
		t_warn;
		stop_test;
	end
	initial begin
		#2000000;
		fail_count++;
		stop_test;
	end
endmodule
